/* rtl/cpu_alu_branch_execute.sv */
// execute core for arithmetic, logic, multiply, jump, call, skip and branch words
// assumes prog_data holds the word at prog_addr in the same cycle; io_bits is the
// bit-addressable I/O space, byte n at bits [8n+7:8n]; APB master holds until pready
// What this block does
// - add two registers, optionally with carry; Z,C,N,V,H; one cycle.
// - add or subtract immediate to a register pair word; Z,C,N,V,S; two cycles.
// - subtract register or immediate, optionally with carry; Z,C,N,V,H; one cycle.
// - and, or with register or immediate, xor with register only; only Z,N,V; one cycle.
// - twos negate is 0x00 minus reg; ones invert is 0xFF minus reg.
// - clear mask ands with inverted mask, set mask ors; Z,N,V.
// - inc, dec, test, clear set Z,N,V; set-all-ones changes no flags.
// - three multiplies put 16-bit product in R1:R0; Z,C; two cycles.
// - fractional multiplies shift product left one; Z,C; two cycles.
// - relative jump 2 cycles, pointer jump 2, absolute jump 3.
// - relative and pointer calls 3 cycles, absolute call 4; flags kept.
// - both returns pop the stack in four cycles; arithmetic flags kept.
// - compare-skip-equal skips next word(s) when equal; no flag change.
// - compares evaluate a difference without storing; Z,N,V,C,H.
// - skip on register bit clear or set.
// - skip on I/O bit clear or set.
// - generic branch on chosen flag set or clear adds offset plus one.
// - named branches are the generic branch on a single flag.
// - signed ge branches when N xor V is 0, lt when 1.
// - I/O skips address only I/O bytes 0x00 to 0x1F.
`timescale 1ns/1ns
module cpu_alu_branch_execute
  import cpu_exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [15:0] prog_data,
  input  wire logic [255:0] io_bits,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic [15:0]      prog_addr
);

  exec_state_t state;
  exec_state_t next_state;
  logic [7:0]  gpr [32];
  logic [7:0]  next_gpr [32];
  logic [15:0] stack [STACK_DEPTH];
  logic [15:0] next_stack [STACK_DEPTH];
  logic [3:0]  sp;
  logic [3:0]  next_sp;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [7:0]  flags;
  logic [7:0]  next_flags;
  logic [1:0]  stall;
  logic [1:0]  next_stall;
  logic        run;
  logic        next_run;
  logic        call_long;
  logic        next_call_long;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;

  assign prog_addr = pc;

  // {h, v, c, result}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [7:0] r;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    r = s[7:0];
    add8 = {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
            (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]), s[8], r};
  endfunction

  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [7:0] r;
    s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    r = s[7:0];
    sub8 = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
            (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]), s[8], r};
  endfunction

  // the second word of an absolute jump or call must be stepped over too
  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[GRP_HI:GRP_LO] == GRP_MISC) && (w[11:10] == MISC_FLOW)
               && ((w[3:0] == FLOW_JMP) || (w[3:0] == FLOW_CALL));
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= OFS_STATE);
  endfunction

  always_comb begin
    logic [15:0] w;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [7:0]  dv;
    logic [7:0]  sv;
    logic [7:0]  kv;
    logic [10:0] alu;
    logic [15:0] wsum;
    logic [15:0] prod;
    logic [15:0] ret_pc;
    logic        upd_nv;
    logic        cond;
    logic        wr_acc;
    w = prog_data;
    rd = w[8:4];
    rr = w[4:0];
    dv = 8'h00;
    sv = 8'h00;
    kv = w[7:0];
    alu = 11'h000;
    wsum = 16'h0000;
    prod = 16'h0000;
    ret_pc = pc + 16'h0001;
    upd_nv = 1'b0;
    cond = 1'b0;
    wr_acc = 1'b0;
    next_state = state;
    next_gpr = gpr;
    next_stack = stack;
    next_sp = sp;
    next_pc = pc;
    next_flags = flags;
    next_stall = stall;
    next_run = run;
    next_call_long = call_long;
    unique case (state)
      ST_HALT: begin
        if (run) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!run) begin
          next_state = ST_HALT;
        end else begin
          next_pc = pc + 16'h0001;
          unique case (w[GRP_HI:GRP_LO])
            GRP_SUB_IMM, GRP_SUB_IMM_BRW, GRP_AND_IMM, GRP_OR_IMM, GRP_CMP_IMM,
            GRP_CLR_MASK, GRP_SET_MASK: begin
              rd = IMM_REG_BASE | {1'b0, w[11:8]};
              dv = gpr[rd];
              upd_nv = 1'b1;
              if (w[GRP_HI:GRP_LO] == GRP_SUB_IMM || w[GRP_HI:GRP_LO] == GRP_SUB_IMM_BRW
                  || w[GRP_HI:GRP_LO] == GRP_CMP_IMM) begin
                alu = sub8(dv, kv, (w[GRP_HI:GRP_LO] == GRP_SUB_IMM_BRW) & flags[FL_C]);
                next_flags[FL_H] = alu[10];
                next_flags[FL_C] = alu[8];
                if (w[GRP_HI:GRP_LO] == GRP_SUB_IMM_BRW) begin
                  next_flags[FL_Z] = (alu[7:0] == 8'h00) & flags[FL_Z];
                end else begin
                  next_flags[FL_Z] = (alu[7:0] == 8'h00);
                end
                if (w[GRP_HI:GRP_LO] != GRP_CMP_IMM) begin
                  next_gpr[rd] = alu[7:0];
                end
              end else begin
                // immediate logic, Z N V only
                unique case (w[GRP_HI:GRP_LO])
                  GRP_AND_IMM:  alu[7:0] = dv & kv;
                  GRP_CLR_MASK: alu[7:0] = dv & (8'hFF - kv);
                  default:  alu[7:0] = dv | kv;
                endcase
                next_flags[FL_Z] = (alu[7:0] == 8'h00);
                next_gpr[rd] = alu[7:0];
              end
              next_flags[FL_N] = alu[7];
              next_flags[FL_V] = alu[9];
            end
            GRP_WORD: begin
              // pair word add or subtract, two cycles
              rd = PAIR_BASE | {2'b00, w[9:8], 1'b0};
              if (w[11]) begin
                wsum = {gpr[rd + 5'd1], gpr[rd]} - {10'h000, w[5:0]};
                next_flags[FL_C] = ~gpr[rd + 5'd1][7] & wsum[15];
                next_flags[FL_V] = gpr[rd + 5'd1][7] & ~wsum[15];
              end else begin
                wsum = {gpr[rd + 5'd1], gpr[rd]} + {10'h000, w[5:0]};
                next_flags[FL_C] = gpr[rd + 5'd1][7] & ~wsum[15];
                next_flags[FL_V] = ~gpr[rd + 5'd1][7] & wsum[15];
              end
              next_gpr[rd] = wsum[7:0];
              next_gpr[rd + 5'd1] = wsum[15:8];
              next_flags[FL_N] = wsum[15];
              next_flags[FL_Z] = (wsum == 16'h0000);
              upd_nv = 1'b1;
              next_stall = XTRA_TWO;
              next_state = ST_STALL;
            end
            GRP_ARITH, GRP_CMP: begin
              rd = w[9:5];
              dv = gpr[rd];
              sv = gpr[rr];
              if (w[GRP_HI:GRP_LO] == GRP_CMP && w[11:10] == SUB_CMP_SKIP) begin
                if (dv == sv) begin
                  next_state = ST_SKIP;
                end
              end else begin
                if (w[GRP_HI:GRP_LO] == GRP_ARITH && !w[11]) begin
                  alu = add8(dv, sv, (w[11:10] == SUB_ADC) & flags[FL_C]);
                end else begin
                  alu = sub8(dv, sv, w[10] & flags[FL_C]);
                end
                next_flags[FL_H] = alu[10];
                next_flags[FL_V] = alu[9];
                next_flags[FL_C] = alu[8];
                next_flags[FL_N] = alu[7];
                // carry-chained subtracts only keep Z when all bytes are zero
                if (w[10] && (w[11] || w[GRP_HI:GRP_LO] == GRP_CMP)) begin
                  next_flags[FL_Z] = (alu[7:0] == 8'h00) & flags[FL_Z];
                end else begin
                  next_flags[FL_Z] = (alu[7:0] == 8'h00);
                end
                upd_nv = 1'b1;
                if (w[GRP_HI:GRP_LO] == GRP_ARITH) begin
                  next_gpr[rd] = alu[7:0];
                end
              end
            end
            GRP_LOGIC: begin
              rd = w[9:5];
              dv = gpr[rd];
              sv = gpr[rr];
              unique case (w[11:10])
                SUB_AND: alu[7:0] = dv & sv;
                SUB_OR:  alu[7:0] = dv | sv;
                default: alu[7:0] = dv ^ sv;
              endcase
              next_gpr[rd] = alu[7:0];
              next_flags[FL_Z] = (alu[7:0] == 8'h00);
              next_flags[FL_N] = alu[7];
              next_flags[FL_V] = 1'b0;
              upd_nv = 1'b1;
            end
            GRP_MUL: begin
              rd = {2'b10, w[8:6]};
              rr = {2'b10, w[2:0]};
              dv = gpr[rd];
              sv = gpr[rr];
              unique case (w[10:9])
                2'h0:    prod = {8'h00, dv} * {8'h00, sv};
                2'h1:    prod = 16'($signed(dv) * $signed(sv));
                default: prod = 16'($signed({{8{dv[7]}}, dv}) * $signed({8'h00, sv}));
              endcase
              next_flags[FL_C] = prod[15];
              if (w[11]) begin
                prod = {prod[14:0], 1'b0};
              end
              next_flags[FL_Z] = (prod == 16'h0000);
              next_gpr[0] = prod[7:0];
              next_gpr[1] = prod[15:8];
              next_stall = XTRA_TWO;
              next_state = ST_STALL;
            end
            GRP_SINGLE: begin
              dv = gpr[rd];
              upd_nv = 1'b1;
              unique case (w[3:0])
                ONE_INVERT: begin
                  alu = {2'b00, 1'b1, 8'hFF - dv};
                  next_flags[FL_C] = 1'b1;
                end
                ONE_NEGATE: begin
                  alu = sub8(8'h00, dv, 1'b0);
                  next_flags[FL_C] = alu[8];
                  next_flags[FL_H] = alu[10];
                end
                ONE_INC: alu = {1'b0, dv == 8'h7F, 1'b0, dv + 8'h01};
                ONE_DEC: alu = {1'b0, dv == 8'h80, 1'b0, dv - 8'h01};
                ONE_TEST: alu = {3'b000, dv & dv};
                ONE_CLR: alu = {3'b000, dv ^ dv};
                default: begin
                  upd_nv = 1'b0;
                  alu = {3'b000, 8'hFF};
                end
              endcase
              if (upd_nv) begin
                next_flags[FL_Z] = (alu[7:0] == 8'h00);
                next_flags[FL_N] = alu[7];
                next_flags[FL_V] = alu[9];
              end
              if (w[3:0] <= ONE_ONES) begin
                next_gpr[rd] = alu[7:0];
              end
            end
            GRP_SKIPREG: begin
              if (gpr[rr][w[10:8]] == w[11]) begin
                next_state = ST_SKIP;
              end
            end
            GRP_REL: begin
              unique case (w[11:10])
                REL_JUMP, REL_CALL: begin
                  next_pc = pc + {{6{w[9]}}, w[9:0]} + 16'h0001;
                  next_stall = XTRA_TWO;
                  if (w[10]) begin
                    next_stack[sp] = ret_pc;
                    next_sp = sp + 4'h1;
                    next_stall = XTRA_THREE;
                  end
                  next_state = ST_STALL;
                end
                default: begin
                  // named branches are these with fixed flag
                  // signed tests read S, which is N xor V
                  cond = (flags[w[9:7]] == ~w[10]);
                  if (cond) begin
                    next_pc = pc + {{9{w[6]}}, w[6:0]} + 16'h0001;
                    next_stall = XTRA_TWO;
                    next_state = ST_STALL;
                  end
                end
              endcase
            end
            GRP_MISC: begin
              if (w[11:10] == MISC_IOSKIP) begin
                // five-bit address reaches bytes 0x00 to 0x1F only
                if (io_bits[{w[8:4], w[2:0]}] == w[9]) begin
                  next_state = ST_SKIP;
                end
              end else if (w[11:10] == MISC_FLOW) begin
                unique case (w[3:0])
                  FLOW_PTR_JUMP, FLOW_PTR_CALL: begin
                    next_pc = {gpr[Z_LOW + 5'd1], gpr[Z_LOW]};
                    next_stall = XTRA_TWO;
                    if (w[0]) begin
                      next_stack[sp] = ret_pc;
                      next_sp = sp + 4'h1;
                      next_stall = XTRA_THREE;
                    end
                    next_state = ST_STALL;
                  end
                  FLOW_BACK, FLOW_INT_BACK: begin
                    next_sp = sp - 4'h1;
                    next_pc = stack[sp - 4'h1];
                    if (w[0]) begin
                      next_flags[FL_I] = 1'b1;
                    end
                    // long cycle plus two stalls
                    next_stall = XTRA_THREE;
                    next_call_long = 1'b1;
                    next_state = ST_LONG;
                  end
                  FLOW_JMP, FLOW_CALL: begin
                    next_call_long = w[0];
                    next_state = ST_LONG;
                  end
                  default: next_state = ST_EXEC;
                endcase
              end
            end
            default: next_state = ST_EXEC;
          endcase
          if (upd_nv) begin
            next_flags[FL_S] = next_flags[FL_N] ^ next_flags[FL_V];
          end
        end
      end
      ST_LONG: begin
        // second word holds the absolute target
        // absolute call pushes address after the target word
        // returns arrive with the stall count loaded and the counter already moved
        if (stall != 2'h0) begin
          next_state = ST_STALL;
        end else begin
          next_pc = prog_data;
          next_stall = call_long ? XTRA_THREE : XTRA_TWO;
          if (call_long) begin
            next_stack[sp] = ret_pc;
            next_sp = sp + 4'h1;
          end
          next_state = ST_STALL;
        end
        next_call_long = 1'b0;
      end
      ST_STALL: begin
        next_stall = stall - 2'h1;
        if (stall <= 2'h1) begin
          next_state = ST_EXEC;
          next_stall = 2'h0;
        end
      end
      ST_SKIP: begin
        // two-word target costs a third cycle
        next_pc = pc + 16'h0001;
        next_state = ST_EXEC;
        if (two_word(prog_data)) begin
          next_pc = pc + 16'h0002;
          next_stall = XTRA_TWO;
          next_state = ST_STALL;
        end
      end
      default: next_state = ST_HALT;
    endcase
    // APB: one wait-free access phase; core state writable only when halted
    wr_acc = psel & penable & pready & pwrite;
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & (~is_mapped(paddr) | (pwrite & (paddr == OFS_STATE)));
    next_prdata = 32'h0000_0000;
    if (psel && !penable && is_mapped(paddr)) begin
      if (paddr <= OFS_GPR_LAST) begin
        next_prdata = {24'h000000, gpr[paddr[6:2]]};
      end else if (paddr == OFS_FLAGS) begin
        next_prdata = {24'h000000, flags};
      end else if (paddr == OFS_PC) begin
        next_prdata = {16'h0000, pc};
      end else if (paddr == OFS_CTRL) begin
        next_prdata = {31'h00000000, run};
      end else begin
        next_prdata = {25'h0000000, sp, state};
      end
    end
    if (wr_acc && !pslverr) begin
      if (paddr == OFS_CTRL) begin
        next_run = pwdata[CTRL_RUN];
      end else if (state == ST_HALT) begin
        if (paddr <= OFS_GPR_LAST) begin
          next_gpr[paddr[6:2]] = pwdata[7:0];
        end else if (paddr == OFS_FLAGS) begin
          next_flags = pwdata[7:0];
        end else if (paddr == OFS_PC) begin
          next_pc = pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_HALT;
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= 8'h00;
      end
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= RST_PC;
      end
      sp <= 4'h0;
      pc <= RST_PC;
      flags <= RST_FLAGS;
      stall <= 2'h0;
      run <= 1'b0;
      call_long <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      gpr <= next_gpr;
      stack <= next_stack;
      sp <= next_sp;
      pc <= next_pc;
      flags <= next_flags;
      stall <= next_stall;
      run <= next_run;
      call_long <= next_call_long;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

endmodule

/* inc/cpu_exec_pkg.sv */
// constants, encodings and types for the execute core
// assumes 16-bit program words and an APB register port with 32-bit data
package cpu_exec_pkg;
  // instruction word fields
  localparam int GRP_HI = 15;
  localparam int GRP_LO = 12;
  localparam logic [3:0] GRP_SUB_IMM     = 4'h0;
  localparam logic [3:0] GRP_SUB_IMM_BRW = 4'h1;
  localparam logic [3:0] GRP_AND_IMM     = 4'h2;
  localparam logic [3:0] GRP_OR_IMM      = 4'h3;
  localparam logic [3:0] GRP_CMP_IMM     = 4'h4;
  localparam logic [3:0] GRP_CLR_MASK    = 4'h5;
  localparam logic [3:0] GRP_SET_MASK    = 4'h6;
  localparam logic [3:0] GRP_WORD  = 4'h7;
  localparam logic [3:0] GRP_ARITH = 4'h8;
  localparam logic [3:0] GRP_LOGIC = 4'h9;
  localparam logic [3:0] GRP_CMP   = 4'hA;
  localparam logic [3:0] GRP_MUL   = 4'hB;
  localparam logic [3:0] GRP_SINGLE = 4'hC;
  localparam logic [3:0] GRP_SKIPREG = 4'hD;
  localparam logic [3:0] GRP_REL   = 4'hE;
  localparam logic [3:0] GRP_MISC  = 4'hF;
  // two-bit sub codes of the register-pair groups
  localparam logic [1:0] SUB_ADD = 2'h0;
  localparam logic [1:0] SUB_ADC = 2'h1;
  localparam logic [1:0] SUB_SUB = 2'h2;
  localparam logic [1:0] SUB_SUB_BRW = 2'h3;
  localparam logic [1:0] SUB_AND = 2'h0;
  localparam logic [1:0] SUB_OR  = 2'h1;
  localparam logic [1:0] SUB_XOR = 2'h2;
  localparam logic [1:0] SUB_CMP  = 2'h0;
  localparam logic [1:0] SUB_CMP_BRW = 2'h1;
  localparam logic [1:0] SUB_CMP_SKIP = 2'h2;
  // single-register sub codes
  localparam logic [3:0] ONE_INVERT = 4'h0;
  localparam logic [3:0] ONE_NEGATE = 4'h1;
  localparam logic [3:0] ONE_INC = 4'h2;
  localparam logic [3:0] ONE_DEC = 4'h3;
  localparam logic [3:0] ONE_TEST = 4'h4;
  localparam logic [3:0] ONE_CLR = 4'h5;
  localparam logic [3:0] ONE_ONES = 4'h6;
  // misc group sub codes, bits [11:10] select the kind
  localparam logic [1:0] MISC_FLOW = 2'h0;
  localparam logic [1:0] MISC_IOSKIP = 2'h3;
  localparam logic [3:0] FLOW_PTR_JUMP = 4'h0;
  localparam logic [3:0] FLOW_PTR_CALL = 4'h1;
  localparam logic [3:0] FLOW_BACK     = 4'h2;
  localparam logic [3:0] FLOW_INT_BACK = 4'h3;
  localparam logic [3:0] FLOW_JMP   = 4'h4;
  localparam logic [3:0] FLOW_CALL  = 4'h5;
  // relative group kinds
  localparam logic [1:0] REL_JUMP = 2'h0;
  localparam logic [1:0] REL_CALL = 2'h1;
  localparam logic [1:0] REL_BSET = 2'h2;
  localparam logic [1:0] REL_BCLR = 2'h3;
  // immediate register base and word-pair base
  localparam logic [4:0] IMM_REG_BASE = 5'h10;
  localparam logic [4:0] PAIR_BASE    = 5'h18;
  localparam logic [4:0] Z_LOW        = 5'h1E;
  // status flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  // extra cycles beyond the first
  localparam logic [1:0] XTRA_TWO   = 2'h1;
  localparam logic [1:0] XTRA_THREE = 2'h2;
  // APB map
  localparam logic [11:0] OFS_GPR_LAST = 12'h07C;
  localparam logic [11:0] OFS_FLAGS    = 12'h080;
  localparam logic [11:0] OFS_PC       = 12'h084;
  localparam logic [11:0] OFS_CTRL     = 12'h088;
  localparam logic [11:0] OFS_STATE    = 12'h08C;
  localparam int CTRL_RUN = 0;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam int STACK_DEPTH = 16;
  typedef enum logic [2:0] {
    ST_HALT  = 3'b000,
    ST_EXEC  = 3'b001,
    ST_LONG  = 3'b011,
    ST_STALL = 3'b010,
    ST_SKIP  = 3'b110
  } exec_state_t;
endpackage

/* sim/exec_props.sv */
// checker for the execute core: APB answer and program counter steps
// assumes one clock domain and the package encodings
`timescale 1ns/1ns
module exec_props
  import cpu_exec_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] prog_data,
  input wire logic [15:0] prog_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  // register writes move the counter too, so those cycles are left out
  sequence s_moved; $changed(prog_addr) && !$past(psel); endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_bad_addr: assert property (s_setup ##0 (paddr > OFS_STATE) |=> pslverr)
    else $error("unmapped access accepted");
  a_state_ro: assert property (s_setup ##0 (pwrite && paddr == OFS_STATE) |=> pslverr)
    else $error("state write accepted");
  a_reset_pc: assert property ($fell(sys_rst) |-> prog_addr == RST_PC && !pready)
    else $error("counter not reset");
  a_alu_step: assert property (s_moved ##0
    ($past(prog_data[15:12]) inside {[4'h0:4'h9], 4'hB, 4'hC})
    // a target word of an absolute jump or call is not an instruction
    && ($past(prog_data[15:10], 2) != 6'h3C)
    |-> prog_addr == $past(prog_addr) + 16'h0001) else $error("alu step wrong");
  a_rel_target: assert property (s_moved ##0 ($past(prog_data[15:11]) == 5'h1C)
    |-> prog_addr == $past(prog_addr) + {{6{$past(prog_data[9])}}, $past(prog_data[9:0])}
    + 16'h0001) else $error("relative target wrong");
  a_branch_target: assert property (s_moved ##0 ($past(prog_data[15:11]) == 5'h1D)
    |-> prog_addr inside {$past(prog_addr) + 16'h0001, $past(prog_addr) + 16'h0001
    + {{9{$past(prog_data[6])}}, $past(prog_data[6:0])}}) else $error("branch target wrong");
  a_skip_step: assert property (s_moved ##0 ($past(prog_data[15:10]) == 6'h2A)
    |-> prog_addr inside {[$past(prog_addr) + 16'h0001 : $past(prog_addr) + 16'h0003]})
    else $error("skip step wrong");
endmodule
bind cpu_alu_branch_execute exec_props exec_props_inst (.clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .prog_data, .prog_addr);

/* sim/prog_mem_model.sv */
// program memory beside the core: combinational word read
// assumes the bench loads mem before the core is started
`timescale 1ns/1ns
module prog_mem_model (
  input wire logic [15:0] addr,
  output logic     [15:0] data
);
  logic [15:0] mem [256];
  // unloaded words hold 0xFFFF, an I/O skip on byte 0x1F bit 7 set, so a runaway core steps on
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  assign data = mem[addr[7:0]];
endmodule

/* sim/tb_top.sv */
// testbench: runs one program through APB control, then reads state back
// assumes the core answers APB with one access cycle
`timescale 1ns/1ns
module tb_top
  import cpu_exec_pkg::*;
;
  logic        clk = 1'b0, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] prog_data, prog_addr;
  int          error_cnt = 0, samples_checked = 0, cnt;
  logic [15:0] prog [20] = '{16'h8211, 16'hB082, 16'h4010, 16'hE881, 16'hC106,
                             16'hAA10, 16'hC106, 16'hE000, 16'hC113, 16'hF005,
                             16'h0010, 16'hDF12, 16'hF004, 16'h0000, 16'hF004,
                             16'h0011, 16'hF002, 16'hFC00, 16'hC106, 16'hE3FF};
  logic [11:0] ra [8] = '{12'h040, 12'h044, 12'h048, 12'h000, 12'h004, OFS_FLAGS,
                          OFS_PC, OFS_STATE};
  logic [31:0] re [8] = '{32'h10, 32'h00, 32'h80, 32'h00, 32'h40, 32'h02, 32'h13, 32'h00};
  always #5 clk = ~clk;
  cpu_alu_branch_execute cpu_alu_branch_execute_inst (.clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prog_data, .io_bits(256'h0), .pready, .pslverr, .prdata,
    .prog_addr);
  prog_mem_model prog_mem_model_inst (.addr(prog_addr), .data(prog_data));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0};
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (prog[i]) prog_mem_model_inst.mem[i] = prog[i];
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, OFS_STATE, 32'h0);
    chk("state write error", 32'h1, {31'h0, er});
    apb(1'b1, 12'h040, 32'h0F);
    apb(1'b1, 12'h044, 32'h01);
    apb(1'b1, 12'h048, 32'h80);
    apb(1'b1, OFS_CTRL, 32'h1);
    cnt = 0;
    while (prog_addr === 16'h0000 && cnt < 50) begin @(posedge clk); cnt++; end
    cnt = 0;
    while (prog_addr !== 16'h0009 && cnt < 50) begin @(posedge clk); cnt++; end
    chk("program cycles", 32'd10, cnt);
    cnt = 0;
    while (prog_addr !== 16'h0013 && cnt < 50) begin @(posedge clk); cnt++; end
    chk("call skip cycles", 32'd16, cnt);
    $display("program test done");
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk($sformatf("offset %h", ra[i]), re[i], rd);
    end
    $display("readback test done");
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    print_verdict;
  end
endmodule
